// file: include/vcpc_defines.vh
`ifndef VCPC_DEFINES_VH
`define VCPC_DEFINES_VH
// ----------------------------------------
// Slave address
// ----------------------------------------
`define VCPC_ADDR_FIXED 5'h10
// ----------------------------------------
// Rate select codes, rate in 100 Hz, knee in 100 Hz
// ----------------------------------------
`define VCPC_RATE_00 8'h50
`define VCPC_RATE_01 8'h40
`define VCPC_RATE_10 8'h35
`define VCPC_RATE_11 8'h28
`define VCPC_KNEE_00 8'h22
`define VCPC_KNEE_01 8'h1B
`define VCPC_KNEE_10 8'h17
`define VCPC_KNEE_11 8'h11
// ----------------------------------------
// Line-in gain in dB
// ----------------------------------------
`define VCPC_LIG_BASE_DB 5'h06
`define VCPC_LIG_STEP_DB 5'h03
`define VCPC_LIG_TOP_DB 5'h0F
// ----------------------------------------
// Route codes
// ----------------------------------------
`define VCPC_ROUTE_OFF 2'h0
`define VCPC_ROUTE_SPK 2'h1
`define VCPC_ROUTE_ARRAY 2'h2
`define VCPC_ROUTE_OUT 2'h3
`endif

// file: core/vcpc_pin_ctrl.v
`timescale 1ns/1ps
`include "vcpc_defines.vh"
module vcpc_pin_ctrl
(
  input wire ref_clk, // System clock, 100 MHz
  input wire reset, // Synchronous, active high
  input wire memory_overflow_flag, // Overflow event pulse
  input wire message_end_marker, // End marker event pulse (incl. cueing)
  input wire status_read, // Status-read instruction pulse
  input wire [7:0] status_byte_in, // Status contents from core
  output reg [7:0] status_byte_out, // Captured status byte
  output reg status_valid, // Status byte ready to shift, pulse
  input wire int_n_in, // Interrupt wire level
  output wire int_n_out, // Interrupt drive value, always low
  output reg int_n_oe, // High while pulling interrupt low
  input wire ext_clk_sel, // Use external reference clock
  input wire ext_ref_clock_in, // External reference, asynchronous
  output reg clk_div2_q, // Divided reference
  output reg [7:0] sample_rate, // Sample rate, 100 Hz units
  output reg [7:0] filter_knee, // Filter knee, 100 Hz units
  input wire rate_filter_sel_hi, // Rate select bit 1
  input wire rate_filter_sel_lo, // Rate select bit 0
  input wire addr_strap_hi, // Address strap bit 1
  input wire addr_strap_lo, // Address strap bit 0
  output reg [6:0] slave_addr, // Seven-bit slave address
  input wire spk_gain_high, // Speaker gain select, 1 gives 1.6
  output reg spk_gain_is_1p6, // Speaker stage gain select
  input wire line_in_gain_hi, // Line-in gain bit 1
  input wire line_in_gain_lo, // Line-in gain bit 0
  output reg [4:0] line_in_gain_db, // Line-in gain in dB
  input wire [1:0] line_route_sel, // Line input route code
  output reg line_to_spk, // Line input to speaker
  output reg line_to_array, // Line input to array
  output reg line_to_out, // Line input to line output
  input wire mic_direct_sel, // Microphone direct path select
  output reg mic_to_preamp, // Mic into auto_gain_preamp
  output reg mic_to_outmux // Mic into line_output mux
);
// ----------------------------------------
// Interrupt latch
// ----------------------------------------
reg int_q;
wire int_n_unused;
assign int_n_out = 1'b0; // Open drain: only ever drives low
assign int_n_unused = int_n_in;
// Event wins over a same-cycle status read, so nothing is lost
always @(posedge ref_clk)
begin
  if (reset)
    int_q <= 1'b0;
  else if (memory_overflow_flag | message_end_marker)
    int_q <= 1'b1;
  else if (status_read)
    int_q <= 1'b0;
end
always @(posedge ref_clk)
begin
  if (reset)
    int_n_oe <= 1'b0;
  else
    int_n_oe <= int_q | memory_overflow_flag | message_end_marker;
end
// Status capture for the serial shifter
always @(posedge ref_clk)
begin
  if (reset)
  begin
    status_byte_out <= 8'h00;
    status_valid <= 1'b0;
  end
  else
  begin
    status_valid <= status_read;
    if (status_read)
      status_byte_out <= status_byte_in;
  end
end
// ----------------------------------------
// External reference divider
// ----------------------------------------
// Three stages; a change counts when second and third agree
reg [2:0] xsync_q;
reg xlvl_q;
always @(posedge ref_clk)
begin
  if (reset)
  begin
    xsync_q <= 3'h0;
    xlvl_q <= 1'b0;
    clk_div2_q <= 1'b0;
  end
  else
  begin
    xsync_q <= {xsync_q[1:0], ext_ref_clock_in};
    if (xsync_q[2] == xsync_q[1])
      xlvl_q <= xsync_q[1];
    // Rising edges only, so duty cycle has no effect
    if (ext_clk_sel && (xsync_q[2] == xsync_q[1]) && xsync_q[1] && !xlvl_q)
      clk_div2_q <= ~clk_div2_q;
    else if (!ext_clk_sel)
      clk_div2_q <= 1'b0;
  end
end
// ----------------------------------------
// Sample rate and filter select
// ----------------------------------------
// Filters follow the select bits in either clock mode, so the host
// must keep a valid code even while the external reference runs
always @(posedge ref_clk)
begin
  if (reset)
  begin
    sample_rate <= `VCPC_RATE_00;
    filter_knee <= `VCPC_KNEE_00;
  end
  else
  begin
    case ({rate_filter_sel_hi, rate_filter_sel_lo})
      2'h0:
      begin
        sample_rate <= `VCPC_RATE_00;
        filter_knee <= `VCPC_KNEE_00;
      end
      2'h1:
      begin
        sample_rate <= `VCPC_RATE_01;
        filter_knee <= `VCPC_KNEE_01;
      end
      2'h2:
      begin
        sample_rate <= `VCPC_RATE_10;
        filter_knee <= `VCPC_KNEE_10;
      end
      default:
      begin
        sample_rate <= `VCPC_RATE_11;
        filter_knee <= `VCPC_KNEE_11;
      end
    endcase
  end
end
// ----------------------------------------
// Slave address straps
// ----------------------------------------
// Straps are board pins, so they pass three stages like the external reference;
// a new level counts only once the second and third stages agree
reg [1:0] strap_s1_q;
reg [1:0] strap_s2_q;
reg [1:0] strap_s3_q;
reg [1:0] strap_q;
always @(posedge ref_clk)
begin
  if (reset)
  begin
    strap_s1_q <= 2'h0;
    strap_s2_q <= 2'h0;
    strap_s3_q <= 2'h0;
    strap_q <= 2'h0;
  end
  else
  begin
    strap_s1_q <= {addr_strap_hi, addr_strap_lo};
    strap_s2_q <= strap_s1_q;
    strap_s3_q <= strap_s2_q;
    if (strap_s2_q == strap_s3_q)
      strap_q <= strap_s3_q;
  end
end
// Fixed upper part never changes; read/write flag is added by the shifter
always @(posedge ref_clk)
begin
  if (reset)
    slave_addr <= {`VCPC_ADDR_FIXED, 2'h0};
  else
    slave_addr <= {`VCPC_ADDR_FIXED, strap_q};
end
// ----------------------------------------
// Line input gain
// ----------------------------------------
// Base gain plus one step per code; top code is base plus three steps
always @(posedge ref_clk)
begin
  if (reset)
    line_in_gain_db <= `VCPC_LIG_BASE_DB;
  else
  begin
    case ({line_in_gain_hi, line_in_gain_lo})
      2'h0: line_in_gain_db <= `VCPC_LIG_BASE_DB;
      2'h1: line_in_gain_db <= `VCPC_LIG_BASE_DB + `VCPC_LIG_STEP_DB;
      2'h2: line_in_gain_db <= `VCPC_LIG_BASE_DB + `VCPC_LIG_STEP_DB + `VCPC_LIG_STEP_DB;
      default: line_in_gain_db <= `VCPC_LIG_TOP_DB;
    endcase
  end
end
// ----------------------------------------
// Speaker gain and line input routing
// ----------------------------------------
// One route at a time; the off code leaves the line input unconnected
always @(posedge ref_clk)
begin
  if (reset)
  begin
    spk_gain_is_1p6 <= 1'b0;
    line_to_spk <= 1'b0;
    line_to_array <= 1'b0;
    line_to_out <= 1'b0;
  end
  else
  begin
    spk_gain_is_1p6 <= spk_gain_high;
    line_to_spk <= (line_route_sel == `VCPC_ROUTE_SPK);
    line_to_array <= (line_route_sel == `VCPC_ROUTE_ARRAY);
    line_to_out <= (line_route_sel == `VCPC_ROUTE_OUT);
  end
end
// ----------------------------------------
// Microphone path
// ----------------------------------------
// Exactly one mic path is live, so the preamp and mux never both load it
always @(posedge ref_clk)
begin
  if (reset)
  begin
    mic_to_preamp <= 1'b1;
    mic_to_outmux <= 1'b0;
  end
  else
  begin
    mic_to_preamp <= ~mic_direct_sel;
    mic_to_outmux <= mic_direct_sel;
  end
end
endmodule

// file: verification/vcpc_monitor.sv
`timescale 1ns/1ps
module vcpc_monitor
(
  input wire ref_clk, // Clock
  input wire reset, // Sync reset
  input wire memory_overflow_flag, // Event
  input wire message_end_marker, // Event
  input wire status_read, // Read pulse
  input wire status_valid, // Byte ready
  input wire int_n_oe, // Pull enable
  input wire int_n_out, // Pull value
  input wire rate_filter_sel_hi, // Rate bit 1
  input wire rate_filter_sel_lo, // Rate bit 0
  input wire [7:0] sample_rate, // Rate
  input wire [7:0] filter_knee // Knee
);
  // Either event source counts alike
  wire ev = memory_overflow_flag | message_end_marker;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  a_int_raise: assert property (ev |=> int_n_oe) else $error("no raise");
  a_int_hold: assert property (int_n_oe && !status_read && !($past(status_read) && !$past(ev))
    |=> int_n_oe) else $error("drop");
  a_int_clear: assert property (status_read && !ev ##1 !ev |=> !int_n_oe) else $error("kept");
  a_stat_pulse: assert property (status_read |=> status_valid) else $error("no byte");
  a_int_quiet: assert property (!int_n_oe && !ev |=> !int_n_oe) else $error("spurious");
  a_pull_low: assert property (int_n_oe |-> !int_n_out) else $error("not low");
  a_rate_code: assert property ({rate_filter_sel_hi, rate_filter_sel_lo} == 2'h2
    |=> sample_rate == 8'h35) else $error("rate");
  a_knee_code: assert property ({rate_filter_sel_hi, rate_filter_sel_lo} == 2'h3
    |=> filter_knee == 8'h11) else $error("knee");
endmodule

// file: verification/vcpc_host_model.sv
`timescale 1ns/1ps
module vcpc_host_model
#(parameter DLY = 4)
(
  input wire ref_clk, // Clock
  input wire int_n, // Interrupt wire
  input wire status_valid, // Byte ready
  input wire [7:0] status_byte_out, // Status byte
  output reg status_read, // Read request
  output reg [7:0] got_byte // Last byte read
);
  // Slow reader; waits out the release so one event gives one read
  initial
  begin
    status_read = 1'b0;
    forever
    begin
      @(negedge ref_clk);
      if (int_n === 1'b0)
      begin
        repeat (DLY) @(negedge ref_clk);
        status_read = 1'b1;
        @(negedge ref_clk);
        status_read = 1'b0;
        repeat (3) @(negedge ref_clk);
      end
    end
  end
  // Byte taken in its one valid cycle
  always @(posedge ref_clk)
    if (status_valid)
      got_byte <= status_byte_out;
endmodule

// file: verification/vcpc_pin_ctrl_tb.sv
`timescale 1ns/1ps
module vcpc_pin_ctrl_tb;
  reg ref_clk = 1'b0, reset = 1'b1, memory_overflow_flag = 1'b0, message_end_marker = 1'b0;
  reg ext_clk_sel = 1'b0, ext_ref_clock_in = 1'b0, mic_direct_sel = 1'b0;
  reg [1:0] code = 2'h0;
  reg [7:0] status_byte_in = 8'h00;
  wire int_n_in, status_read, status_valid, int_n_out, int_n_oe, clk_div2_q, spk_gain_is_1p6;
  wire line_to_spk, line_to_array, line_to_out, mic_to_preamp, mic_to_outmux;
  wire [7:0] status_byte_out, sample_rate, filter_knee, got_byte;
  wire [6:0] slave_addr;
  wire [4:0] line_in_gain_db;
  wire rate_filter_sel_hi = code[1], rate_filter_sel_lo = code[0], addr_strap_hi = code[1];
  wire addr_strap_lo = code[0], line_in_gain_hi = code[1], line_in_gain_lo = code[0];
  wire [1:0] line_route_sel = code;
  wire spk_gain_high = mic_direct_sel;
  integer miscompares = 0, comparisons = 0, i;
  reg p;
  assign int_n_in = int_n_oe ? int_n_out : 1'b1; // Pull-up when released
  vcpc_pin_ctrl dut (.ref_clk(ref_clk), .reset(reset),
    .memory_overflow_flag(memory_overflow_flag), .message_end_marker(message_end_marker),
    .status_read(status_read), .status_byte_in(status_byte_in),
    .status_byte_out(status_byte_out), .status_valid(status_valid),
    .int_n_in(int_n_in), .int_n_out(int_n_out), .int_n_oe(int_n_oe),
    .ext_clk_sel(ext_clk_sel), .ext_ref_clock_in(ext_ref_clock_in),
    .clk_div2_q(clk_div2_q), .sample_rate(sample_rate), .filter_knee(filter_knee),
    .rate_filter_sel_hi(rate_filter_sel_hi), .rate_filter_sel_lo(rate_filter_sel_lo),
    .addr_strap_hi(addr_strap_hi), .addr_strap_lo(addr_strap_lo), .slave_addr(slave_addr),
    .spk_gain_high(spk_gain_high), .spk_gain_is_1p6(spk_gain_is_1p6),
    .line_in_gain_hi(line_in_gain_hi), .line_in_gain_lo(line_in_gain_lo),
    .line_in_gain_db(line_in_gain_db), .line_route_sel(line_route_sel),
    .line_to_spk(line_to_spk), .line_to_array(line_to_array), .line_to_out(line_to_out),
    .mic_direct_sel(mic_direct_sel), .mic_to_preamp(mic_to_preamp),
    .mic_to_outmux(mic_to_outmux));
  vcpc_host_model #(.DLY(4)) host (.ref_clk(ref_clk), .int_n(int_n_in),
    .status_valid(status_valid), .status_byte_out(status_byte_out),
    .status_read(status_read), .got_byte(got_byte));
  // Clocks; reference near 4.096 MHz, unrelated in phase
  initial forever #5 ref_clk = ~ref_clk;
  initial forever #122.07 ext_ref_clock_in = ~ext_ref_clock_in;
  task chk(input string nm, input [7:0] g, input [7:0] e);
  begin
    comparisons = comparisons + 1;
    if (g !== e)
    begin
      miscompares = miscompares + 1;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  end
  endtask
  task close_out;
  begin
    if (miscompares == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  end
  endtask
  // One event, then the host clears it
  task t_int(input e);
  begin
    status_byte_in = {7'h2C, e};
    memory_overflow_flag = e;
    message_end_marker = !e;
    @(negedge ref_clk);
    memory_overflow_flag = 1'b0;
    message_end_marker = 1'b0;
    chk("int", int_n_in, 1'h0);
    for (i = 0; i < 20 && int_n_in !== 1'b1; i = i + 1) @(negedge ref_clk);
    chk("release", int_n_in, 1'h1);
    chk("status", got_byte, status_byte_in);
    if (i == 20) close_out;
  end
  endtask
  // Every code of each select field
  task t_cfg;
  for (i = 0; i < 4; i = i + 1)
  begin
    code = i[1:0];
    mic_direct_sel = i[0];
    repeat (6) @(negedge ref_clk);
    chk("rate", sample_rate, 32'h50403528 >> (24 - 8 * i));
    chk("knee", filter_knee, 32'h221B1711 >> (24 - 8 * i));
    chk("gain", line_in_gain_db, 6 + 3 * i);
    chk("addr", slave_addr, {5'h10, code});
    chk("route", {line_to_spk, line_to_array, line_to_out}, (i == 0) ? 3'h0 : 3'h4 >> (i - 1));
    chk("mic", {mic_to_preamp, mic_to_outmux}, i[0] ? 2'h1 : 2'h2);
    chk("spk", spk_gain_is_1p6, i[0]);
  end
  endtask
  // Divided reference flips once per reference period
  task t_div;
  begin
    code = 2'h1;
    ext_clk_sel = 1'b1;
    repeat (3) @(negedge ext_ref_clock_in);
    chk("xknee", filter_knee, 8'h1B);
    p = clk_div2_q;
    repeat (4)
    begin
      @(negedge ext_ref_clock_in);
      chk("div", clk_div2_q, !p);
      p = clk_div2_q;
    end
    @(negedge ref_clk);
    ext_clk_sel = 1'b0;
  end
  endtask
  initial
  begin
    repeat (8) @(negedge ref_clk);
    chk("rst", {int_n_oe, clk_div2_q, status_valid}, 8'h00);
    reset = 1'b0;
    t_cfg;
    t_int(1'b1);
    t_int(1'b0);
    t_div;
    close_out;
  end
endmodule
bind vcpc_pin_ctrl vcpc_monitor mon (.ref_clk(ref_clk), .reset(reset),
  .memory_overflow_flag(memory_overflow_flag), .message_end_marker(message_end_marker),
  .status_read(status_read), .status_valid(status_valid), .int_n_oe(int_n_oe),
  .int_n_out(int_n_out), .rate_filter_sel_hi(rate_filter_sel_hi),
  .rate_filter_sel_lo(rate_filter_sel_lo), .sample_rate(sample_rate),
  .filter_knee(filter_knee));
